// file: verilog/qpot_top.sv
// two-wire slave register access for a quad digital potentiometer
// ==========================================================
`timescale 1ns/1ps
`include "qpot_consts.svh"
module qpot_top #(
	// arbitrary neutral device type code
	parameter logic [3:0]  DEV_TYPE  = 4'h9,
	parameter int unsigned NV_CYCLES = `QPOT_NV_CYCLES
) (
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	// two-wire bus, open drain data line
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	// configuration pins
	input  wire logic [2:0]           hw_addr_i,
	input  wire logic                 wp_n_i,
	// wiper positions and status
	output logic [31:0]               wiper_pos_o,
	output logic                      nv_busy_o,
	output qpot_pkg::qpot_byte_t      selection_status_o
);
	import qpot_pkg::*;

	// ==========================================================
	// pin synchronisation and bus events
	logic [5:0] pins_s;
	qpot_sync #(.W(6)) qpot_sync_inst (
		.sys_clk_i (sys_clk_i),
		.nrst_i    (nrst_i),
		.pin_i     ({scl_i, sda_i, wp_n_i, hw_addr_i}),
		.sync_o    (pins_s)
	);
	logic       scl_s;
	logic       sda_s;
	logic       wp_s;
	logic [2:0] hw_addr_s;
	assign scl_s     = pins_s[5];
	assign sda_s     = pins_s[4];
	assign wp_s      = pins_s[3];
	assign hw_addr_s = pins_s[2:0];

	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ==========================================================
	// state
	qpot_state_e state_q, state_d;
	qpot_phase_e phase_q, phase_d;
	logic [3:0]  bitcnt_q, bitcnt_d;
	qpot_byte_t  shift_q, shift_d;
	qpot_byte_t  tx_q, tx_d;
	logic        rw_q, rw_d;
	logic        mack_q, mack_d;
	logic        sda_oe_q, sda_oe_d;
	logic [2:0]  addr_q, addr_d;
	logic [1:0]  ch_q, ch_d;
	qpot_byte_t  status_q, status_d;
	qpot_byte_t  wiper_q [4];
	qpot_byte_t  wiper_d [4];
	qpot_byte_t  nv_q [16];
	qpot_byte_t  nv_d [16];
	qpot_byte_t  pend_q [4];
	qpot_byte_t  pend_d [4];
	logic [3:0]  pend_v_q, pend_v_d;
	logic        busy_q, busy_d;
	logic [31:0] cnt_q, cnt_d;
	logic        wr_pot_ev;
	logic        rd_load_ev;
	qpot_byte_t  rd_val;

	function automatic logic [1:0] ch_next(input logic [1:0] ch);
		ch_next = ch + 2'd1;
	endfunction : ch_next

	function automatic logic [3:0] nv_idx(input logic [1:0] bank, input logic [1:0] ch);
		nv_idx = {bank, ch};
	endfunction : nv_idx

	logic       nv_sel;
	logic [1:0] bank;
	assign nv_sel = status_q[`QPOT_STATUS_NV_BIT];
	assign bank   = status_q[`QPOT_STATUS_BANK_HI:`QPOT_STATUS_BANK_LO];

	// ==========================================================
	// next state
	always_comb begin
		state_d    = state_q;
		phase_d    = phase_q;
		bitcnt_d   = bitcnt_q;
		shift_d    = shift_q;
		tx_d       = tx_q;
		rw_d       = rw_q;
		mack_d     = mack_q;
		sda_oe_d   = sda_oe_q;
		addr_d     = addr_q;
		ch_d       = ch_q;
		status_d   = status_q;
		wiper_d    = wiper_q;
		nv_d       = nv_q;
		pend_d     = pend_q;
		pend_v_d   = pend_v_q;
		busy_d     = busy_q;
		cnt_d      = cnt_q;
		wr_pot_ev  = 1'b0;
		rd_load_ev = 1'b0;
		// read source follows address and selection bits
		if (addr_q == `QPOT_ADDR_STATUS)
			rd_val = status_q;
		else if (addr_q > `QPOT_ADDR_POT_LAST)
			rd_val = `QPOT_UNUSED_READ;
		else if (nv_sel)
			rd_val = nv_q[nv_idx(bank, ch_q)];
		else
			rd_val = wiper_q[ch_q];
		if (busy_q) begin
			// bus is deaf and the line stays released while programming
			state_d  = QPOT_IDLE;
			sda_oe_d = 1'b0;
			cnt_d    = cnt_q - 32'd1;
			if (cnt_q <= 32'd1)
				busy_d = 1'b0;
		end else if (start_ev) begin
			state_d  = QPOT_RX;
			phase_d  = QPOT_PH_DEV;
			bitcnt_d = 4'd0;
			sda_oe_d = 1'b0;
		end else if (stop_ev) begin
			state_d  = QPOT_IDLE;
			sda_oe_d = 1'b0;
			pend_v_d = 4'h0;
			if (|pend_v_q && wp_s) begin
				for (int j = 0; j < 4; j++) begin
					if (pend_v_q[j])
						nv_d[nv_idx(bank, j[1:0])] = pend_q[j];
				end
				busy_d = 1'b1;
				cnt_d  = NV_CYCLES;
			end
		end else begin
			unique case (state_q)
				QPOT_IDLE: begin
				end
				QPOT_RX: begin
					if (scl_rise && bitcnt_q < 4'd8) begin
						shift_d  = {shift_q[6:0], sda_s};
						bitcnt_d = bitcnt_q + 4'd1;
					end else if (scl_fall && bitcnt_q == 4'd8) begin
						state_d  = QPOT_ACK;
						sda_oe_d = 1'b1;
						unique case (phase_q)
							QPOT_PH_DEV: begin
								if (shift_q[7:4] == DEV_TYPE && shift_q[3:1] == hw_addr_s) begin
									rw_d = shift_q[0];
									if (!shift_q[0])
										phase_d = QPOT_PH_REG;
								end else begin
									state_d  = QPOT_IDLE;
									sda_oe_d = 1'b0;
								end
							end
							QPOT_PH_REG: begin
								addr_d  = shift_q[2:0];
								phase_d = QPOT_PH_DATA;
								if (shift_q[2:0] <= `QPOT_ADDR_POT_LAST)
									ch_d = shift_q[1:0];
							end
							QPOT_PH_DATA: begin
								if (addr_q == `QPOT_ADDR_STATUS) begin
									status_d = shift_q;
								end else if (addr_q <= `QPOT_ADDR_POT_LAST) begin
									wr_pot_ev       = 1'b1;
									wiper_d[ch_q]   = shift_q;
									ch_d            = ch_next(ch_q);
									if (nv_sel) begin
										pend_d[ch_q]   = shift_q;
										pend_v_d[ch_q] = 1'b1;
									end
								end
							end
							default: begin
								state_d  = QPOT_IDLE;
								sda_oe_d = 1'b0;
							end
						endcase
					end
				end
				QPOT_ACK: begin
					if (scl_fall) begin
						bitcnt_d = 4'd0;
						if (rw_q) begin
							rd_load_ev = 1'b1;
							state_d    = QPOT_TX;
							tx_d       = rd_val;
							sda_oe_d   = ~rd_val[7];
						end else begin
							state_d  = QPOT_RX;
							sda_oe_d = 1'b0;
						end
					end
				end
				QPOT_TX: begin
					if (scl_fall) begin
						if (bitcnt_q == 4'd7) begin
							state_d  = QPOT_RACK;
							sda_oe_d = 1'b0;
						end else begin
							tx_d     = {tx_q[6:0], 1'b0};
							sda_oe_d = ~tx_q[6];
							bitcnt_d = bitcnt_q + 4'd1;
						end
					end
				end
				QPOT_RACK: begin
					if (scl_rise)
						mack_d = ~sda_s;
					else if (scl_fall) begin
						bitcnt_d = 4'd0;
						if (mack_q) begin
							rd_load_ev = 1'b1;
							state_d    = QPOT_TX;
							tx_d       = rd_val;
							sda_oe_d   = ~rd_val[7];
						end else begin
							state_d = QPOT_IDLE;
						end
					end
				end
				default: begin
					state_d  = QPOT_IDLE;
					sda_oe_d = 1'b0;
				end
			endcase
			// a pot read moves nonvolatile data into the wiper when the nonvolatile bit is set, and always advances the channel
			if (rd_load_ev && addr_q <= `QPOT_ADDR_POT_LAST) begin
				if (nv_sel)
					wiper_d[ch_q] = rd_val;
				ch_d = ch_next(ch_q);
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state_q    <= QPOT_IDLE;
			phase_q    <= QPOT_PH_DEV;
			bitcnt_q   <= 4'd0;
			shift_q    <= 8'h00;
			tx_q       <= 8'h00;
			rw_q       <= 1'b0;
			mack_q     <= 1'b0;
			sda_oe_q   <= 1'b0;
			addr_q     <= 3'h0;
			ch_q       <= 2'h0;
			status_q   <= `QPOT_STATUS_RESET;
			wiper_q    <= '{default: `QPOT_WIPER_RESET};
			nv_q       <= '{default: `QPOT_NV_RESET};
			pend_q     <= '{default: 8'h00};
			pend_v_q   <= 4'h0;
			busy_q     <= 1'b0;
			cnt_q      <= 32'd0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			state_q    <= state_d;
			phase_q    <= phase_d;
			bitcnt_q   <= bitcnt_d;
			shift_q    <= shift_d;
			tx_q       <= tx_d;
			rw_q       <= rw_d;
			mack_q     <= mack_d;
			sda_oe_q   <= sda_oe_d;
			addr_q     <= addr_d;
			ch_q       <= ch_d;
			status_q   <= status_d;
			wiper_q    <= wiper_d;
			nv_q       <= nv_d;
			pend_q     <= pend_d;
			pend_v_q   <= pend_v_d;
			busy_q     <= busy_d;
			cnt_q      <= cnt_d;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign sda_o              = 1'b0;
	assign sda_oe_o           = sda_oe_q;
	assign nv_busy_o          = busy_q;
	assign selection_status_o = status_q;
	assign wiper_pos_o        = {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]};

	// ==========================================================
	// assertions
	sequence s_commit;
		stop_ev && !busy_q && |pend_v_q && wp_s;
	endsequence
	sequence s_busy_run;
		busy_q [*8];
	endsequence

	property p_busy_quiet;
		@(posedge sys_clk_i) disable iff (!nrst_i) busy_q |=> !sda_oe_q;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("line driven while busy");

	property p_commit;
		@(posedge sys_clk_i) disable iff (!nrst_i) s_commit |=> s_busy_run;
	endproperty
	a_commit: assert property (p_commit) else $error("stop did not start programming");

	property p_wp_block;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			stop_ev && !busy_q && !wp_s |=> !busy_q && pend_v_q == 4'h0;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("programming without write enable");

	property p_wiper_load;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			wr_pot_ev && !busy_q && !stop_ev |=> wiper_q[$past(ch_q)] == $past(shift_q);
	endproperty
	a_wiper_load: assert property (p_wiper_load) else $error("wiper not loaded on write");

	property p_ch_wrap;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			wr_pot_ev && !busy_q && !stop_ev |=> ch_q == ch_next($past(ch_q));
	endproperty
	a_ch_wrap: assert property (p_ch_wrap) else $error("channel counter wrong");

	property p_read_move;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			rd_load_ev && nv_sel && addr_q <= `QPOT_ADDR_POT_LAST
			|=> wiper_q[$past(ch_q)] == tx_q;
	endproperty
	a_read_move: assert property (p_read_move) else $error("read did not move data");

	property p_reset_ptr;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			$rose(nrst_i) |-> status_q == `QPOT_STATUS_RESET && ch_q == 2'h0 && addr_q == 3'h0;
	endproperty
	a_reset_ptr: assert property (p_reset_ptr) else $error("bad reset pointer");

	property p_busy_len;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			$rose(busy_q) |-> cnt_q == NV_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming length wrong");

	property p_status_write;
		@(posedge sys_clk_i) disable iff (!nrst_i)
			state_q == QPOT_RX && phase_q == QPOT_PH_DATA && addr_q == `QPOT_ADDR_STATUS
			&& scl_fall && bitcnt_q == 4'd8 && !busy_q && !start_ev && !stop_ev
			|=> status_q == $past(shift_q) ##1 state_q != QPOT_RX || sda_oe_q;
	endproperty
	a_status_write: assert property (p_status_write) else $error("status write lost");
endmodule : qpot_top

// file: verilog/qpot_consts.svh
// constants for the quad potentiometer two-wire register access block
`ifndef QPOT_CONSTS_SVH
`define QPOT_CONSTS_SVH
// ==========================================================
// register address byte decode
`define QPOT_ADDR_STATUS    3'h7
`define QPOT_ADDR_POT_LAST  3'h3
// ==========================================================
// selection status register layout and reset
`define QPOT_STATUS_RESET   8'h00
`define QPOT_STATUS_NV_BIT  0
`define QPOT_STATUS_BANK_LO 1
`define QPOT_STATUS_BANK_HI 2
// ==========================================================
// reset contents of wipers and nonvolatile data, and the value read from unused addresses
`define QPOT_WIPER_RESET    8'h00
`define QPOT_NV_RESET       8'h00
`define QPOT_UNUSED_READ    8'h00
// ==========================================================
// timing: nonvolatile cycle in microseconds, system clock in kHz
`define QPOT_NV_TIME_US     5000
`define QPOT_SYS_CLK_KHZ    10000
`define QPOT_NV_CYCLES      ((`QPOT_NV_TIME_US * `QPOT_SYS_CLK_KHZ) / 1000)
`endif

// file: verilog/qpot_pkg.sv
// types shared by the quad potentiometer two-wire block
package qpot_pkg;
	typedef enum logic [4:0] {
		QPOT_IDLE = 5'h01,
		QPOT_RX   = 5'h02,
		QPOT_ACK  = 5'h04,
		QPOT_TX   = 5'h08,
		QPOT_RACK = 5'h10
	} qpot_state_e;
	typedef enum logic [2:0] {
		QPOT_PH_DEV  = 3'h1,
		QPOT_PH_REG  = 3'h2,
		QPOT_PH_DATA = 3'h4
	} qpot_phase_e;
	typedef logic [7:0] qpot_byte_t;
endpackage : qpot_pkg

// file: verilog/qpot_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module qpot_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	// pins in, synchronised out
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;
	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
	end
	// resets high: an idle two-wire bus reads as released
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign sync_o = sync_q;
endmodule : qpot_sync

// file: test/qpot_master.sv
// two-wire bus master model for the potentiometer block's serial pins
`timescale 1ns/1ps
module qpot_master (
	// clock and resolved data wire
	input  wire logic sys_clk_i,
	input  wire logic sda_i,
	// master pins, data is open drain
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end
	// ==========================================================
	// bit timing: a quarter of the 800 ns period, just after a clock edge
	task automatic q;
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask : q
	// also serves as repeated start when entered with the clock low
	task automatic start;
		sda_low_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_low_o = 1'b1;
		q();
		scl_o = 1'b0;
		q();
	endtask : start
	task automatic stop;
		sda_low_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_low_o = 1'b0;
		q();
	endtask : stop
	// data changes only while the clock is low, sampled mid-high
	task automatic bit_x(input logic b, output logic r);
		sda_low_o = !b;
		q();
		scl_o = 1'b1;
		q();
		r = sda_i;
		q();
		scl_o = 1'b0;
		q();
	endtask : bit_x
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(b[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask : wr_byte
	task automatic rd_byte(input logic ack_m, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(!ack_m, r);
	endtask : rd_byte
endmodule : qpot_master

// file: test/quad_pot_two_wire_register_access_bench.sv
// self-checking bench for the quad potentiometer two-wire block
`timescale 1ns/1ps
module quad_pot_two_wire_register_access_bench;
	// arbitrary type code, handed to the block as well
	localparam logic [3:0] TYPE  = 4'h9;
	localparam logic [2:0] HW    = 3'h5;
	localparam int         NV    = 200;
	localparam int         LIMIT = 30000;
	logic        sys_clk_i;
	logic        nrst_i;
	logic        scl;
	logic        m_low;
	logic        sda_line;
	logic        sda_o;
	logic        sda_oe_o;
	logic [2:0]  hw_addr_i;
	logic        wp_n_i;
	logic [31:0] wiper_pos_o;
	logic        nv_busy_o;
	logic [7:0]  selection_status_o;
	int          n_fail;
	int          total_checks;
	int          busy_cnt;
	int          cyc;
	// the wire is pulled up unless someone pulls it low
	assign sda_line = !(m_low || (sda_oe_o && !sda_o));
	qpot_top #(.DEV_TYPE(TYPE), .NV_CYCLES(NV)) qpot_top_inst (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .hw_addr_i(hw_addr_i), .wp_n_i(wp_n_i),
		.wiper_pos_o(wiper_pos_o), .nv_busy_o(nv_busy_o),
		.selection_status_o(selection_status_o));
	qpot_master qpot_master_inst (.sys_clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl),
		.sda_low_o(m_low));
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cyc++;
		if (nv_busy_o === 1'b1) busy_cnt++;
		if (cyc == LIMIT) begin
			n_fail++;
			wrap_up();
		end
	end
	// ==========================================================
	// shared checking and bus tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic k0, k1, k2;
		busy_cnt = 0;
		qpot_master_inst.start();
		qpot_master_inst.wr_byte({TYPE, HW, 1'b0}, k0);
		qpot_master_inst.wr_byte(a, k1);
		qpot_master_inst.wr_byte(d, k2);
		qpot_master_inst.stop();
		chk("write acks", 32'({k0, k1, k2}), 32'h7);
	endtask : wr_reg
	task automatic rd_seq(input logic rnd, input logic [7:0] a, input int n,
		input logic [31:0] exp);
		logic       k;
		logic [7:0] d;
		qpot_master_inst.start();
		if (rnd) begin
			qpot_master_inst.wr_byte({TYPE, HW, 1'b0}, k);
			chk("read setup ack", 32'(k), 32'h1);
			qpot_master_inst.wr_byte(a, k);
			chk("read register ack", 32'(k), 32'h1);
			qpot_master_inst.start();
		end
		qpot_master_inst.wr_byte({TYPE, HW, 1'b1}, k);
		chk("read address ack", 32'(k), 32'h1);
		for (int i = 0; i < n; i++) begin
			qpot_master_inst.rd_byte(i < n - 1, d);
			chk("read byte", 32'(d), 32'(exp[8*i +: 8]));
		end
		qpot_master_inst.stop();
	endtask : rd_seq
	task automatic nv_done(input logic prog);
		logic k;
		repeat (4) @(posedge sys_clk_i);
		#1;
		chk("busy after stop", 32'(nv_busy_o), 32'(prog));
		qpot_master_inst.start();
		qpot_master_inst.wr_byte({TYPE, HW, 1'b0}, k);
		qpot_master_inst.stop();
		chk("ack after stop", 32'(k), 32'(!prog));
		for (int i = 0; i < 400 && nv_busy_o !== 1'b0; i++) @(posedge sys_clk_i);
		#1;
		chk("busy length", 32'(busy_cnt), prog ? 32'(NV) : 32'h0);
	endtask : nv_done
	// ==========================================================
	// scenarios
	task automatic t_reset;
		chk("wipers at reset", wiper_pos_o, 32'h0);
		chk("status at reset", 32'(selection_status_o), 32'h0);
		rd_seq(1'b0, 8'h00, 1, 32'h0);
	endtask : t_reset
	task automatic t_miss;
		logic k;
		for (int i = 0; i < 2; i++) begin
			qpot_master_inst.start();
			qpot_master_inst.wr_byte({TYPE ^ 4'(i), HW ^ 3'(1 - i), 1'b0}, k);
			qpot_master_inst.stop();
			chk("foreign address ack", 32'(k), 32'h0);
		end
	endtask : t_miss
	task automatic t_writes;
		wr_reg(8'h01, 8'h5a);
		chk("volatile wiper", 32'(wiper_pos_o[15:8]), 32'h5a);
		nv_done(1'b0);
		wr_reg(8'h07, 8'h03);
		chk("status", 32'(selection_status_o), 32'h03);
		wr_reg(8'h02, 8'h3a);
		chk("wiper follows data", 32'(wiper_pos_o[23:16]), 32'h3a);
		nv_done(1'b1);
	endtask : t_writes
	task automatic t_page;
		logic k;
		busy_cnt = 0;
		qpot_master_inst.start();
		qpot_master_inst.wr_byte({TYPE, HW, 1'b0}, k);
		qpot_master_inst.wr_byte(8'h02, k);
		for (int i = 1; i <= 5; i++) begin
			qpot_master_inst.wr_byte(8'(8'h11 * i), k);
			chk("page byte ack", 32'(k), 32'h1);
		end
		qpot_master_inst.stop();
		chk("page wipers", wiper_pos_o, 32'h22554433);
		nv_done(1'b1);
	endtask : t_page
	task automatic t_read;
		wr_reg(8'h07, 8'h00);
		wr_reg(8'h03, 8'h77);
		chk("wiper before move", 32'(wiper_pos_o[31:24]), 32'h77);
		wr_reg(8'h07, 8'h03);
		rd_seq(1'b1, 8'h03, 2, 32'h00003322);
		chk("wipers after move", wiper_pos_o, 32'h22554433);
		rd_seq(1'b0, 8'h00, 1, 32'h44);
	endtask : t_read
	task automatic t_protect;
		wp_n_i = 1'b0;
		wr_reg(8'h00, 8'h99);
		chk("protected wiper", 32'(wiper_pos_o[7:0]), 32'h99);
		nv_done(1'b0);
		wp_n_i = 1'b1;
		rd_seq(1'b1, 8'h00, 1, 32'h33);
	endtask : t_protect
	task automatic t_unused;
		wr_reg(8'h05, 8'hee);
		chk("unused write", wiper_pos_o, 32'h22554433);
		rd_seq(1'b1, 8'h04, 1, 32'h00);
		rd_seq(1'b1, 8'h07, 1, 32'h03);
	endtask : t_unused
	task automatic t_bank;
		wr_reg(8'h07, 8'h05);
		wr_reg(8'h01, 8'h6c);
		chk("bank2 wiper", 32'(wiper_pos_o[15:8]), 32'h6c);
		nv_done(1'b1);
		wr_reg(8'h07, 8'h03);
		rd_seq(1'b1, 8'h01, 1, 32'h44);
		wr_reg(8'h07, 8'h05);
		rd_seq(1'b1, 8'h01, 1, 32'h6c);
		wr_reg(8'h07, 8'h01);
		rd_seq(1'b1, 8'h03, 1, 32'h00);
		chk("bank moves", wiper_pos_o, 32'h00556c33);
	endtask : t_bank
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		n_fail = 0;
		total_checks = 0;
		busy_cnt = 0;
		cyc = 0;
		nrst_i = 1'b0;
		hw_addr_i = HW;
		wp_n_i = 1'b1;
		repeat (5) @(posedge sys_clk_i);
		#1;
		nrst_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		#1;
		t_reset();
		t_miss();
		t_writes();
		t_page();
		t_read();
		t_protect();
		t_unused();
		t_bank();
		wrap_up();
	end
endmodule : quad_pot_two_wire_register_access_bench
